/* File: core/input_delay_filter.sv */
// Purpose: Per-channel input delay filter counting in 0.2 ms steps
// Assumes: pin_i synchronous to clk_i, step_i a one-cycle pulse
// Notes:   A delay of zero passes the pin straight to the level register
`timescale 1ns/1ps
module input_delay_filter (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Timing and setting
  input  wire logic       step_i,
  input  wire logic [6:0] delay_i,
  // Signal
  input  wire logic       pin_i,
  output logic            level_o
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       level;
  } filt_state_t;

  filt_state_t st;
  filt_state_t next_st;

  // Level follows the pin only after it stayed different for the delay
  // The first step after a change may be partial, so one extra step is
  // counted: the delay is never shorter than the setting, at most one step longer
  always_comb
  begin
    next_st = st;
    if (pin_i == st.level)
    begin
      next_st.cnt = 7'h00;
    end
    else if (delay_i == 7'h00)
    begin
      next_st.level = pin_i;
    end
    else if (step_i)
    begin
      if (st.cnt >= delay_i)
      begin
        next_st.level = pin_i;
        next_st.cnt   = 7'h00;
      end
      else
      begin
        next_st.cnt = st.cnt + 7'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign level_o = st.level;
endmodule

/* File: core/io_counter_gate_filter.sv */
// Purpose: Twelve I/O channels, event counter or gate meter, analog input
// Assumes: Pins and converter strobes synchronous to clk_i at 20 MHz
// Notes:   Registers sit on a classic Wishbone slave with one wait state
// What this block does
// - Falling edges on channel one bump a 16-bit wrapping counter.
// - One counter channel, either event counting or gate measuring, selected.
// - Gate mode counts time-base ticks from rising to falling edge.
// - Gate time base is 48 MHz, 3 MHz or 187.5 kHz.
// - Input delay filter 0 to 25 ms in 0.2 ms steps, reset zero.
// - When enabled, captured input highs are held until cleared.
// - Each of twelve channels is set as input or output.
// - Analog value is 12-bit result times eight, 0x0000 to 0x7FFF.
// - Undershoot reports 0x0000, overshoot reports 0x7FFF.
// - Analog value comes from one 12-bit converter channel.
// - Analog value checked against configurable upper and lower limits.
// - Analog filter limits the ramp per update.
// - Each driven output is watched for short circuit or overload.
// - Local I/O cycle runs 1:1 or prescaled from the bus cycle.
`timescale 1ns/1ps
module io_counter_gate_filter (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Channel pins
  input  wire logic [11:0] ch_pin_i,
  output logic      [11:0] ch_out_o,
  output logic      [11:0] ch_oe_n_o,
  input  wire logic [11:0] ch_short_i,
  // Analog converter
  input  wire logic        adc_valid_i,
  input  wire logic [11:0] adc_data_i,
  input  wire logic        adc_under_i,
  input  wire logic        adc_over_i,
  // Bus cycle and interrupt
  input  wire logic        bus_cycle_i,
  output logic             io_cycle_o,
  output logic             irq_o
);
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] out;
    logic [11:0] image;
    logic [11:0] latch;
    logic        gate_mode;
    logic [1:0]  tbase;
    logic        latch_en;
    logic [7:0]  presc;
    logic [6:0]  filt;
    logic [15:0] count;
    logic [15:0] gate_run;
    logic [15:0] gate_res;
    logic        gate_act;
    logic [19:0] tacc;
    logic [15:0] ana;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] ramp;
    logic [15:0] stat;
    logic [15:0] mask;
    logic [7:0]  pdiv;
    logic        io_cyc;
    logic [11:0] step_cnt;
    logic        step;
    logic        cnt_prev;
    logic        gate_prev;
    logic        ack;
    logic [31:0] dat;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  logic [11:0] filt_lvl;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Ticks owed this cycle by the fractional time-base accumulator
  function automatic logic [1:0] tick_count(input logic [20:0] sum);
    if (sum >= 21'(3) * {1'b0, io_gate_pkg::TB_DIV})
      return 2'h3;
    else if (sum >= 21'(2) * {1'b0, io_gate_pkg::TB_DIV})
      return 2'h2;
    else if (sum >= {1'b0, io_gate_pkg::TB_DIV})
      return 2'h1;
    else
      return 2'h0;
  endfunction

  // One delay filter per channel
  // per-channel delay filter
  for (genvar g = 0; g < io_gate_pkg::CHANNELS; g++)
  begin : g_filt
    input_delay_filter u_filt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .step_i  (st.step),
      .delay_i (st.filt),
      .pin_i   (ch_pin_i[g]),
      .level_o (filt_lvl[g])
    );
  end

  logic        bus_req;
  logic        wr_now;
  logic [7:0]  adr;
  logic [19:0] tinc;
  logic [20:0] tsum;
  logic [1:0]  ticks;
  logic [15:0] target;
  logic [15:0] wstat;
  logic [31:0] rd;
  logic [31:0] wv;
  logic        cnt_fall;
  logic        gate_rise;
  logic        gate_fall;

  // Bus decode; writes land on the edge that samples ack high
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign wr_now    = bus_req & wb_we_i & st.ack;
  assign adr       = {wb_adr_i[7:2], 2'b00};
  assign cnt_fall  = st.cnt_prev & ~ch_pin_i[0];
  assign gate_rise = ~st.gate_prev & ch_pin_i[1];
  assign gate_fall = st.gate_prev & ~ch_pin_i[1];

  // Time base increment and tick extraction
  // time base selection
  always_comb
  begin
    case (st.tbase)
      io_gate_pkg::TB_SEL_48M: tinc = io_gate_pkg::TB_INC_48M;
      io_gate_pkg::TB_SEL_3M:  tinc = io_gate_pkg::TB_INC_3M;
      default:                 tinc = io_gate_pkg::TB_INC_187K;
    endcase
    tsum  = {1'b0, st.tacc} + {1'b0, tinc};
    ticks = tick_count(tsum);
  end

  // Converter scaling and overload clamp
  // scale by eight; clamp; single converter
  always_comb
  begin
    if (adc_under_i)
      target = io_gate_pkg::ANA_MIN;
    else if (adc_over_i)
      target = io_gate_pkg::ANA_MAX;
    else
      target = {1'b0, adc_data_i, 3'b000};
  end

  // Read mux; unmapped offsets answer with zero
  always_comb
  begin
    case (adr)
      io_gate_pkg::ADR_DIR:    rd = {20'h00000, st.dir};
      io_gate_pkg::ADR_OUT:    rd = {20'h00000, st.out};
      io_gate_pkg::ADR_IN:     rd = {20'h00000, st.image};
      io_gate_pkg::ADR_LATCH:  rd = {20'h00000, st.latch};
      io_gate_pkg::ADR_CTRL:   rd = {16'h0000, st.presc, 4'h0, st.latch_en, st.tbase,
                                     st.gate_mode};
      io_gate_pkg::ADR_FILT:   rd = {25'h0000000, st.filt};
      io_gate_pkg::ADR_COUNT:  rd = {16'h0000, st.count};
      io_gate_pkg::ADR_GATE:   rd = {16'h0000, st.gate_res};
      io_gate_pkg::ADR_ANALOG: rd = {16'h0000, st.ana};
      io_gate_pkg::ADR_UPPER:  rd = {16'h0000, st.upper};
      io_gate_pkg::ADR_LOWER:  rd = {16'h0000, st.lower};
      io_gate_pkg::ADR_RAMP:   rd = {16'h0000, st.ramp};
      io_gate_pkg::ADR_STAT:   rd = {16'h0000, st.stat};
      io_gate_pkg::ADR_MASK:   rd = {16'h0000, st.mask};
      io_gate_pkg::ADR_SHORT:  rd = {20'h00000, ch_short_i & st.dir};
      default:                 rd = 32'h00000000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;
    wv      = 32'h00000000;
    wstat   = 16'h0000;
    // Single wait state: ack rises one cycle after the request, drops after
    next_st.ack = bus_req & ~st.ack;
    next_st.dat = rd;
    // Filter step timer, a free running 0.2 ms pulse
    next_st.step = (st.step_cnt == io_gate_pkg::STEP_CYCLES - 12'h001);
    next_st.step_cnt = next_st.step ? 12'h000 : st.step_cnt + 12'h001;
    // prescaled io cycle, prescaler zero gives 1:1
    next_st.io_cyc = 1'b0;
    if (bus_cycle_i)
    begin
      if (st.pdiv >= st.presc)
      begin
        next_st.pdiv   = 8'h00;
        next_st.io_cyc = 1'b1;
      end
      else
      begin
        next_st.pdiv = st.pdiv + 8'h01;
      end
    end
    // Input image sampled once per local cycle so a read sees one snapshot
    if (st.io_cyc)
      next_st.image = filt_lvl & ~st.dir;
    // falling edge counter, wraps naturally at 16 bits
    next_st.cnt_prev  = ch_pin_i[0];
    next_st.gate_prev = ch_pin_i[1];
    if (!st.gate_mode && cnt_fall)
      next_st.count = st.count + 16'h0001;
    // gate ticks from rising to falling edge
    next_st.tacc = st.tacc;
    if (st.gate_mode && gate_rise)
    begin
      next_st.gate_act = 1'b1;
      next_st.gate_run = 16'h0000;
      next_st.tacc     = 20'h00000;
    end
    else if (st.gate_mode && st.gate_act)
    begin
      next_st.tacc = 20'(tsum - 21'(ticks) * {1'b0, io_gate_pkg::TB_DIV});
      next_st.gate_run = st.gate_run + {14'h0000, ticks};
      // result register only loads at the falling edge
      if (gate_fall)
      begin
        next_st.gate_act = 1'b0;
        next_st.gate_res = st.gate_run + {14'h0000, ticks};
        wstat[io_gate_pkg::ST_GATE] = 1'b1;
      end
    end
    // ramp limit per converter update, zero means unlimited
    if (adc_valid_i)
    begin
      if (st.ramp == 16'h0000)
        next_st.ana = target;
      else if (target > st.ana)
        next_st.ana = (target - st.ana > st.ramp) ? st.ana + st.ramp : target;
      else
        next_st.ana = (st.ana - target > st.ramp) ? st.ana - st.ramp : target;
      // limit checks on the reported value
      wstat[io_gate_pkg::ST_UPPER] = next_st.ana > st.upper;
      wstat[io_gate_pkg::ST_LOWER] = next_st.ana < st.lower;
      wstat[io_gate_pkg::ST_RANGE] = adc_under_i | adc_over_i;
    end
    // short or overload on a driven output
    wstat[11:0] = ch_short_i & st.dir;
    // Register writes
    if (wr_now)
    begin
      case (adr)
        io_gate_pkg::ADR_DIR:
          next_st.dir = 12'(merge({20'h00000, st.dir}, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_OUT:
          next_st.out = 12'(merge({20'h00000, st.out}, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_LATCH:
          next_st.latch = st.latch & ~wb_dat_i[11:0];
        io_gate_pkg::ADR_CTRL:
        begin
          wv = merge(rd, wb_dat_i, wb_sel_i);
          next_st.gate_mode = wv[io_gate_pkg::CTRL_MODE];
          next_st.tbase     = wv[io_gate_pkg::CTRL_TB_LSB +: 2];
          next_st.latch_en  = wv[io_gate_pkg::CTRL_LATCH];
          next_st.presc     = wv[io_gate_pkg::CTRL_PRE_LSB +: 8];
          next_st.gate_act  = 1'b0;
        end
        io_gate_pkg::ADR_FILT:
        begin
          // Larger settings clamp to the 25 ms ceiling
          wv = merge(rd, wb_dat_i, wb_sel_i);
          next_st.filt = (wv[31:7] != 25'h0000000 || wv[6:0] > io_gate_pkg::FILT_MAX_STEP)
                         ? io_gate_pkg::FILT_MAX_STEP : wv[6:0];
        end
        io_gate_pkg::ADR_COUNT:
          next_st.count = 16'(merge(rd, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_UPPER:
          next_st.upper = 16'(merge(rd, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_LOWER:
          next_st.lower = 16'(merge(rd, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_RAMP:
          next_st.ramp = 16'(merge(rd, wb_dat_i, wb_sel_i));
        io_gate_pkg::ADR_STAT:
          next_st.stat = st.stat & ~wb_dat_i[15:0];
        io_gate_pkg::ADR_MASK:
          next_st.mask = 16'(merge(rd, wb_dat_i, wb_sel_i));
        default:
          next_st.dir = st.dir;
      endcase
    end
    // latch captured highs; a capture beats a clear in the same cycle
    if (st.latch_en)
      next_st.latch = next_st.latch | (filt_lvl & ~st.dir);
    // Sticky events; set wins over a write-one clear
    next_st.stat = next_st.stat | wstat;
  end

  // State register with reset values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st       <= '0;
      st.filt  <= io_gate_pkg::FILT_RESET;
      st.upper <= io_gate_pkg::UPPER_RESET;
      st.lower <= io_gate_pkg::LOWER_RESET;
      st.ramp  <= io_gate_pkg::RAMP_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs; enable is active low while a channel drives
  assign wb_ack_o   = st.ack;
  assign wb_dat_o   = st.dat;
  assign ch_out_o   = st.out & st.dir;
  assign ch_oe_n_o  = ~st.dir;
  assign io_cycle_o = st.io_cyc;
  assign irq_o      = |(st.stat & st.mask);

  // Bus answer takes one cycle and lasts one cycle
  sequence s_req_new;
    bus_req && !st.ack;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wb_answer;
    @(posedge clk_i) disable iff (rst_i)
      s_req_new |=> s_ack_once;
  endproperty
  a_wb_ack_single: assert property (p_wb_answer) else $error("bus ack not single cycle");

  a_count_fall_edge: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (!st.gate_mode && cnt_fall && !wr_now) |=> (st.count == $past(st.count) + 16'h0001))
    else $error("event counter missed a falling edge");

  a_count_gate_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (st.gate_mode && !wr_now) |=> $stable(st.count))
    else $error("event counter moved in gate mode");

  a_gate_res_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
      !(st.gate_mode && st.gate_act && gate_fall) |=> $stable(st.gate_res))
    else $error("gate result changed without falling edge");

  a_gate_event_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (st.gate_mode && st.gate_act && gate_fall) |=> !st.gate_act && st.stat[12])
    else $error("gate end not flagged");

  a_analog_clamp_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (adc_valid_i && adc_over_i && !adc_under_i && st.ramp == 16'h0000)
      |=> st.ana == io_gate_pkg::ANA_MAX && st.stat[15])
    else $error("overshoot not clamped");

  a_analog_ramp_bound: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (st.ramp != 16'h0000 && $past(st.ramp) == st.ramp) |->
      ((st.ana >= $past(st.ana)) ? (st.ana - $past(st.ana) <= st.ramp)
                                 : ($past(st.ana) - st.ana <= st.ramp)))
    else $error("analog ramp exceeded");

  a_short_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (ch_short_i[0] && st.dir[0]) |=> st.stat[0])
    else $error("short on output not flagged");

  a_dir_drives_pin: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (wr_now && adr == io_gate_pkg::ADR_DIR && wb_sel_i[1:0] == 2'b11)
      |=> (ch_oe_n_o == ~$past(wb_dat_i[11:0])) && ((ch_out_o & ch_oe_n_o) == 12'h000))
    else $error("pin drive does not follow direction write");

  a_io_cycle_ratio: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (bus_cycle_i && st.presc == 8'h00 && st.pdiv == 8'h00) |=> io_cycle_o)
    else $error("io cycle not 1:1 with bus cycle");
endmodule

/* File: core/io_gate_pkg.sv */
// Purpose: Shared constants for the channel, counter and analog block
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes:   Byte offsets are word aligned; unused upper bits read as zero
package io_gate_pkg;
  localparam int          CHANNELS      = 12;
  localparam int          CLK_PERIOD_NS = 50;
  // Input delay filter: step and range in nanoseconds
  localparam int          FILT_STEP_NS  = 200000;
  localparam int          FILT_MAX_NS   = 25000000;
  localparam logic [11:0] STEP_CYCLES   = 12'(FILT_STEP_NS / CLK_PERIOD_NS);
  localparam logic [6:0]  FILT_MAX_STEP = 7'(FILT_MAX_NS / FILT_STEP_NS);
  localparam logic [6:0]  FILT_RESET    = 7'h00;
  // Gate time base as rates in 62.5 Hz units against the 20 MHz clock
  localparam logic [19:0] TB_DIV        = 20'h4E200;
  localparam logic [19:0] TB_INC_48M    = 20'hBB800;
  localparam logic [19:0] TB_INC_3M     = 20'h0BB80;
  localparam logic [19:0] TB_INC_187K   = 20'h00BB8;
  localparam logic [1:0]  TB_SEL_48M    = 2'h0;
  localparam logic [1:0]  TB_SEL_3M     = 2'h1;
  // Register byte offsets
  localparam logic [7:0]  ADR_DIR       = 8'h00;
  localparam logic [7:0]  ADR_OUT       = 8'h04;
  localparam logic [7:0]  ADR_IN        = 8'h08;
  localparam logic [7:0]  ADR_LATCH     = 8'h0C;
  localparam logic [7:0]  ADR_CTRL      = 8'h10;
  localparam logic [7:0]  ADR_FILT      = 8'h14;
  localparam logic [7:0]  ADR_COUNT     = 8'h18;
  localparam logic [7:0]  ADR_GATE      = 8'h1C;
  localparam logic [7:0]  ADR_ANALOG    = 8'h20;
  localparam logic [7:0]  ADR_UPPER     = 8'h24;
  localparam logic [7:0]  ADR_LOWER     = 8'h28;
  localparam logic [7:0]  ADR_RAMP      = 8'h2C;
  localparam logic [7:0]  ADR_STAT      = 8'h30;
  localparam logic [7:0]  ADR_MASK      = 8'h34;
  localparam logic [7:0]  ADR_SHORT     = 8'h38;
  // Control field positions
  localparam int          CTRL_MODE     = 0;
  localparam int          CTRL_TB_LSB   = 1;
  localparam int          CTRL_LATCH    = 3;
  localparam int          CTRL_PRE_LSB  = 8;
  // Status bits above the twelve short-circuit bits
  localparam int          ST_GATE       = 12;
  localparam int          ST_UPPER      = 13;
  localparam int          ST_LOWER      = 14;
  localparam int          ST_RANGE      = 15;
  // Analog format and reset values
  localparam logic [15:0] ANA_MAX       = 16'h7FFF;
  localparam logic [15:0] ANA_MIN       = 16'h0000;
  localparam logic [15:0] UPPER_RESET   = 16'h7FFF;
  localparam logic [15:0] LOWER_RESET   = 16'h0000;
  localparam logic [15:0] RAMP_RESET    = 16'h0000;
endpackage

/* File: verification/field_model.sv */
// Purpose: Sensors and actuators on the twelve channels plus the converter
// Assumes: Driven from the bench through tasks, changes only after clk_i
// Notes:   Lines not qualified by the strobe show inverted data, not stale
`timescale 1ns/1ps
module field_model (
  // Clock
  input  wire logic        clk_i,
  // Drive state from the block
  input  wire logic [11:0] oe_n_i,
  // Field levels
  output logic      [11:0] pin_o,
  output logic      [11:0] short_o,
  output logic             adc_valid_o,
  output logic      [11:0] adc_data_o,
  output logic             under_o,
  output logic             over_o
);
  logic [11:0] fault = 12'h000;
  initial
  begin
    pin_o = 12'h000;
    adc_valid_o = 1'b0;
    adc_data_o = 12'h000;
    under_o = 1'b0;
    over_o = 1'b0;
  end
  // overload only shows where the stage drives
  assign short_o = fault & ~oe_n_i;
  task set_fault(input logic [11:0] f);
    @(posedge clk_i);
    fault <= f;
  endtask
  // square pulse, caller keeps widths legal
  task pulse(input int ch, input int hi, input int lo);
    @(posedge clk_i);
    pin_o[ch] <= 1'b1;
    repeat (hi) @(posedge clk_i);
    pin_o[ch] <= 1'b0;
    repeat (lo) @(posedge clk_i);
  endtask
  // one result, flags only valid with the strobe
  task convert(input logic [11:0] d, input logic u, input logic o);
    @(posedge clk_i);
    adc_valid_o <= 1'b1;
    adc_data_o <= d;
    under_o <= u;
    over_o <= o;
    @(posedge clk_i);
    adc_valid_o <= 1'b0;
    adc_data_o <= ~d;
    under_o <= ~u;
    over_o <= ~o;
  endtask
endmodule

/* File: verification/io_counter_gate_filter_tb.sv */
// Purpose: Self-checking bench for the channel, counter and analog block
// Assumes: Classic Wishbone master, one request at a time
// Notes:   Random stimulus from a fixed seed with corner cases mixed in
`timescale 1ns/1ps
module io_counter_gate_filter_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic        bus = 1'b0;
  logic [31:0] rdat, q;
  logic [11:0] pin, out, oe_n, short, ad, r1, r2, d;
  logic        ack, av, au, ao, io, irq;
  int          failures = 0;
  int          checked = 0;
  int          ios = 0;
  int          n;
  longint      rates[3] = '{48000000, 3000000, 187500};
  // Free-running 20 MHz clock
  always #25 clk_i = ~clk_i;
  // Count local cycle pulses
  always @(posedge clk_i) if (io === 1'b1) ios++;
  io_counter_gate_filter DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ch_pin_i(pin), .ch_out_o(out),
    .ch_oe_n_o(oe_n), .ch_short_i(short), .adc_valid_i(av), .adc_data_i(ad),
    .adc_under_i(au), .adc_over_i(ao), .bus_cycle_i(bus), .io_cycle_o(io),
    .irq_o(irq));
  field_model fm (.clk_i(clk_i), .oe_n_i(oe_n), .pin_o(pin), .short_o(short),
    .adc_valid_o(av), .adc_data_o(ad), .under_o(au), .over_o(ao));
  // Ack and data taken at the rising edge that sees ack high, released there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, wd};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 100);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (k >= 100)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, ack, 1'b1);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    wb(1'b1, a, wd);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Fractional time base, so results are judged within a window
  task rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task bcyc(input int cnt);
    repeat (cnt)
    begin
      @(posedge clk_i);
      bus <= 1'b1;
      @(posedge clk_i);
      bus <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task settle;
    repeat (3) @(negedge clk_i);
  endtask
  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function logic [31:0] ana_exp(input logic [11:0] v, input logic u, input logic o);
    if (u) return 32'h0;
    if (o) return 32'h7FFF;
    return {17'h0, v, 3'h0};
  endfunction
  function logic [31:0] gate_exp(input longint cycles, input longint rate);
    return 32'(cycles * rate / 64'd20000000);
  endfunction
  // Watchdog well past the expected run length
  initial
  begin
    #4000000;
    failures++;
    summarize();
  end
  // Main sequence
  initial
  begin
    void'($urandom(93074));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(io_gate_pkg::ADR_FILT);
    chk(q, 32'h0);
    rd(io_gate_pkg::ADR_UPPER);
    chk(q, 32'h7FFF);
    rd(8'h3C);
    chk(q, 32'h0);
    chk(32'(oe_n), 32'hFFF);
    r1 = 12'($urandom);
    r2 = 12'($urandom);
    wr(io_gate_pkg::ADR_DIR, 32'(r1));
    wr(io_gate_pkg::ADR_OUT, 32'(r2));
    settle();
    chk(32'(out), 32'(r1 & r2));
    chk(32'(oe_n), {20'h00000, ~r1});
    wr(io_gate_pkg::ADR_DIR, 32'h4);
    fm.set_fault(12'h006);
    settle();
    rd(io_gate_pkg::ADR_SHORT);
    chk(q, 32'h4);
    rd(io_gate_pkg::ADR_STAT);
    chk(q & 32'hFFF, 32'h4);
    fm.set_fault(12'h000);
    wr(io_gate_pkg::ADR_DIR, 32'h0);
    wr(io_gate_pkg::ADR_STAT, 32'hFFFF);
    n = 1 + $urandom_range(7);
    repeat (n) fm.pulse(0, 200, 200);
    rd(io_gate_pkg::ADR_COUNT);
    chk(q, 32'(n));
    wr(io_gate_pkg::ADR_COUNT, 32'hFFFE);
    repeat (3) fm.pulse(0, 200, 200);
    rd(io_gate_pkg::ADR_COUNT);
    chk(q, 32'h1);
    for (int t = 0; t < 3; t++)
    begin
      wr(io_gate_pkg::ADR_CTRL, 32'(1 + 2 * t));
      fm.pulse(0, 200, 200);
      fm.pulse(1, 400, 2000);
      rd(io_gate_pkg::ADR_GATE);
      rng(q, gate_exp(400, rates[t]) - 3, gate_exp(400, rates[t]) + 3);
      rd(io_gate_pkg::ADR_STAT);
      chk(32'(q[12]), 32'h1);
      wr(io_gate_pkg::ADR_STAT, 32'h1000);
    end
    rd(io_gate_pkg::ADR_COUNT);
    chk(q, 32'h1);
    wr(io_gate_pkg::ADR_CTRL, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 3) ? 12'hFFF : 12'($urandom);
      fm.convert(d, k == 4, k == 5);
      rd(io_gate_pkg::ADR_ANALOG);
      chk(q, ana_exp(d, k == 4, k == 5));
    end
    wr(io_gate_pkg::ADR_STAT, 32'hFFFF);
    wr(io_gate_pkg::ADR_UPPER, 32'h100);
    wr(io_gate_pkg::ADR_LOWER, 32'h80);
    wr(io_gate_pkg::ADR_MASK, 32'h2000);
    fm.convert(12'h100, 1'b0, 1'b0);
    rd(io_gate_pkg::ADR_STAT);
    chk(q & 32'hF000, 32'h2000);
    chk(32'(irq), 32'h1);
    wr(io_gate_pkg::ADR_STAT, 32'h2000);
    settle();
    chk(32'(irq), 32'h0);
    fm.convert(12'h008, 1'b0, 1'b0);
    settle();
    chk(32'(irq), 32'h0);
    rd(io_gate_pkg::ADR_STAT);
    chk(q & 32'hF000, 32'h4000);
    wr(io_gate_pkg::ADR_UPPER, 32'h7FFF);
    fm.convert(12'h010, 1'b0, 1'b0);
    wr(io_gate_pkg::ADR_RAMP, 32'h10);
    fm.convert(12'h400, 1'b0, 1'b0);
    rd(io_gate_pkg::ADR_ANALOG);
    rng(q, 32'h81, 32'h90);
    wr(io_gate_pkg::ADR_CTRL, 32'h200);
    ios = 0;
    bcyc(6);
    chk(32'(ios), 32'h2);
    wr(io_gate_pkg::ADR_CTRL, 32'h8);
    ios = 0;
    bcyc(3);
    chk(32'(ios), 32'h3);
    fm.pulse(5, 20, 20);
    bcyc(1);
    rd(io_gate_pkg::ADR_LATCH);
    chk(q & 32'h20, 32'h20);
    rd(io_gate_pkg::ADR_IN);
    chk(q & 32'h20, 32'h0);
    wr(io_gate_pkg::ADR_LATCH, 32'h20);
    rd(io_gate_pkg::ADR_LATCH);
    chk(q & 32'h20, 32'h0);
    wr(io_gate_pkg::ADR_FILT, 32'hC8);
    rd(io_gate_pkg::ADR_FILT);
    chk(q, 32'h7D);
    wr(io_gate_pkg::ADR_FILT, 32'h1);
    fm.pulse(6, 3000, 10);
    bcyc(1);
    rd(io_gate_pkg::ADR_LATCH);
    chk(q & 32'h40, 32'h0);
    fm.pulse(6, 9000, 10);
    bcyc(1);
    rd(io_gate_pkg::ADR_LATCH);
    chk(q & 32'h40, 32'h40);
    summarize();
  end
endmodule
